// ==== dv/rsq_chk.sv ====
`default_nettype none
// ***********************************************
// Port checks for the readout sequencer.
// ***********************************************
module rsq_chk (
	input wire logic                       CLK,
	input wire logic                       RST_N,
	input wire logic [7:0]                 S_AXI_AWADDR,
	input wire logic                       S_AXI_AWVALID,
	input wire logic                       S_AXI_AWREADY,
	input wire logic [7:0]                 S_AXI_ARADDR,
	input wire logic                       S_AXI_ARVALID,
	input wire logic                       S_AXI_ARREADY,
	input wire logic [31:0]                S_AXI_RDATA,
	input wire logic [1:0]                 S_AXI_RRESP,
	input wire logic                       S_AXI_RVALID,
	input wire logic                       S_AXI_RREADY,
	input wire logic [1:0]                 SEQ_TRIG_OUT,
	input wire logic [rsq_pkg::SLOT_W-1:0] SLOT_START,
	input wire logic [rsq_pkg::WUNIT_W-1:0] WEIGHT_START,
	input wire logic                       MONITOR_TRIG
);
	logic [7:0] ra_reg;
	logic       word_reg;
	logic       ctl_reg;
	logic       aw;
	assign aw = S_AXI_AWVALID && S_AXI_AWREADY;
	// Ready needs at least one program word after the load address is set.
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ra_reg <= 8'h00;
			word_reg <= 1'b0;
			ctl_reg <= 1'b0;
		end else begin
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				ra_reg <= S_AXI_ARADDR;
			end
			if (aw && S_AXI_AWADDR == rsq_pkg::ADDR_PDATA) begin
				word_reg <= 1'b1;
			end else if (aw && S_AXI_AWADDR == rsq_pkg::ADDR_PADDR) begin
				word_reg <= 1'b0;
			end
			if (aw && S_AXI_AWADDR == rsq_pkg::ADDR_CTRL) begin
				ctl_reg <= 1'b1;
			end
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	property p_mon;
		MONITOR_TRIG |=> !MONITOR_TRIG ##1 !MONITOR_TRIG;
	endproperty
	a_mon: assert property (p_mon) else $error("monitor pulse too long");
	property p_group;
		(SLOT_START != 16'h0000 || WEIGHT_START != 16'h0000) |-> MONITOR_TRIG;
	endproperty
	a_group: assert property (p_group) else $error("start without monitor");
	property p_wtop;
		WEIGHT_START[15:12] == 4'h0;
	endproperty
	a_wtop: assert property (p_wtop) else $error("weight top bits set");
	property p_trig;
		$changed(SEQ_TRIG_OUT) |-> !MONITOR_TRIG ##1 $stable(SEQ_TRIG_OUT)[*2];
	endproperty
	a_trig: assert property (p_trig) else $error("trigger outputs glitch");
	property p_idle;
		!ctl_reg |-> SLOT_START == 16'h0000 && SEQ_TRIG_OUT == 2'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("ran without enable");
	property p_ready;
		S_AXI_RVALID && ra_reg == rsq_pkg::ADDR_STATUS && !word_reg
			|-> !S_AXI_RDATA[rsq_pkg::ST_READY];
	endproperty
	a_ready: assert property (p_ready) else $error("ready without program");
	property p_unmap;
		S_AXI_RVALID && ra_reg > rsq_pkg::ADDR_DIAG
			|-> S_AXI_RRESP == rsq_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read answered");
	property p_rlat;
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
	endproperty
	a_rlat: assert property (p_rlat) else $error("read answer late");
	property p_rhold;
		S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule
bind rsq_top rsq_chk u_chk (
	.CLK, .RST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
	.S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
	.S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .SEQ_TRIG_OUT,
	.SLOT_START, .WEIGHT_START, .MONITOR_TRIG
);
`default_nettype wire

// ==== dv/rsq_far_model.sv ====
`default_nettype none
// ***********************************************
// Player, integration units and trigger loopback.
// ***********************************************
module rsq_far_model (
	input wire logic  clk,
	input wire logic  rst_n,
	input wire logic  mon,
	input wire logic  [15:0] slot,
	input wire logic  [15:0] wunit,
	input wire logic  [1:0] trig_out,
	output logic      [3:0] ro_done,
	output logic      [7:0] seq_in,
	output logic      [31:0] pulses,
	output logic      [15:0] last_slot,
	output logic      [15:0] last_wunit
);
	logic [4:0] dly_reg;
	// Done stays up a few cycles so a wait still being fetched sees it.
	assign ro_done = {3'h0, dly_reg != 5'h00 && dly_reg < 5'h07};
	assign seq_in = {6'h00, trig_out};
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dly_reg <= 5'h00;
			pulses <= 32'h0;
			last_slot <= 16'h0;
			last_wunit <= 16'h0;
		end else if (mon) begin
			dly_reg <= 5'h0B;
			pulses <= pulses + 32'h1;
			last_slot <= slot;
			last_wunit <= wunit;
		end else if (dly_reg != 5'h00) begin
			dly_reg <= dly_reg - 5'h01;
		end
	end
endmodule
`default_nettype wire

// ==== dv/rsq_tb.sv ====
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst_n, sync, mon, awvalid, wvalid, bready, arvalid;
	logic        rready, awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr, seq_in;
	logic [31:0] wdata, rdata, pio, pulses, rd_data;
	logic [1:0]  bresp, rresp, rd_resp, trig_out;
	logic [3:0]  pin_a, pin_b, ro_done;
	logic [15:0] slot, wunit, last_slot, last_wunit;
	int          err_count, tests_run;
	rsq_top dut (
		.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .TRIG_PIN_A(pin_a), .TRIG_PIN_B(pin_b),
		.PARALLEL_IO_BUS(pio), .SYNC_LINK_TRIGGER(sync),
		.SEQ_TRIG_IN(seq_in), .READOUT_DONE(ro_done),
		.SEQ_TRIG_OUT(trig_out), .SLOT_START(slot), .WEIGHT_START(wunit),
		.MONITOR_TRIG(mon)
	);
	rsq_far_model far (
		.clk, .rst_n, .mon, .slot, .wunit, .trig_out, .ro_done, .seq_in,
		.pulses, .last_slot, .last_wunit
	);
	// ***********************************************
	// Bus and checking tasks.
	// ***********************************************
	task end_sim;
		$display("mismatches %0d comparisons %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task halt;
		chk(32'h0, 32'h1);
		end_sim;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (n == 50) halt;
		chk({30'h0, bresp}, {30'h0, rsq_pkg::RESP_OKAY});
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		// Ready comes a cycle late, so the answer must stand unchanged.
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
			if (rvalid) rready <= 1'b1;
		end
		rready <= 1'b0;
		rd_data = rdata;
		rd_resp = rresp;
		if (n == 50) halt;
	endtask
	task st(input logic [31:0] e);
		rd(rsq_pkg::ADDR_STATUS);
		chk(rd_data, e);
	endtask
	function automatic logic [31:0] ins(logic [3:0] op, logic [27:0] a);
		return {op, a};
	endfunction
	task automatic load(input logic [31:0] p[$]);
		wr(rsq_pkg::ADDR_PADDR, 32'h0);
		wr(rsq_pkg::ADDR_PLEN, p.size());
		foreach (p[i]) wr(rsq_pkg::ADDR_PDATA, p[i]);
		wr(rsq_pkg::ADDR_CTRL, 32'h4);
	endtask
	task automatic see(input int c, output int n);
		for (n = 0; n < 300 && pulses == c; n++) @(posedge clk);
		if (n == 300) halt;
	endtask
	// Unless the choice is zero, checks silence while waiting, then applies the chosen trigger.
	task automatic fire(input int f);
		int c, n;
		c = pulses;
		if (f != 0) begin
			repeat (20) @(posedge clk);
			chk(pulses, c);
			case (f)
				1: pin_a[1] <= 1'b1;
				2: pin_b[3] <= 1'b1;
				3: wr(rsq_pkg::ADDR_SWTRIG, 32'h1);
				4: sync <= 1'b1;
				default: pio[5] <= 1'b0;
			endcase
		end
		see(c, n);
		pin_a <= 4'h0;
		pin_b <= 4'h0;
		sync <= 1'b0;
		pio <= 32'hFFFFFFFF;
	endtask
	task automatic go(output int n);
		int c;
		c = pulses;
		wr(rsq_pkg::ADDR_CTRL, 32'h5);
		see(c, n);
	endtask
	// ***********************************************
	// Scenarios.
	// ***********************************************
	task t_ready;
		st(32'h0);
		rd(8'h40);
		chk({30'h0, rd_resp}, {30'h0, rsq_pkg::RESP_SLVERR});
		wr(rsq_pkg::ADDR_PADDR, 32'h0);
		wr(rsq_pkg::ADDR_PLEN, 32'h2);
		wr(rsq_pkg::ADDR_PDATA, ins(rsq_pkg::OPC_ISSUE_RO, 28'h0010001));
		wr(rsq_pkg::ADDR_CTRL, 32'h4);
		st(32'h0);
		wr(rsq_pkg::ADDR_PDATA, ins(rsq_pkg::OPC_END, 28'h0));
		st(32'h1);
		chk(pulses, 32'h0);
	endtask
	task automatic t_fail;
		int c;
		c = pulses;
		wr(rsq_pkg::ADDR_DIAG, 32'h0000005A);
		wr(rsq_pkg::ADDR_CTRL, 32'h0000000D);
		st(32'h005A0004);
		repeat (30) @(posedge clk);
		chk(pulses, c);
		wr(rsq_pkg::ADDR_CTRL, 32'h4);
		st(32'h1);
	endtask
	task automatic t_rerun;
		int c, n;
		c = pulses;
		wr(rsq_pkg::ADDR_CTRL, 32'h7);
		for (int i = 0; i < 3; i++) see(c + i, n);
		wr(rsq_pkg::ADDR_CTRL, 32'h4);
		repeat (10) @(posedge clk);
		c = pulses;
		repeat (30) @(posedge clk);
		chk(pulses, c);
	endtask
	task automatic t_fields;
		int c, n;
		// The jump skips one readout, so only the second one may appear.
		load('{ins(rsq_pkg::OPC_SET_TRIG, 28'hFFFFFF6),
			ins(rsq_pkg::OPC_JUMP, 28'h0000003),
			ins(rsq_pkg::OPC_ISSUE_RO, 28'h0000003),
			ins(rsq_pkg::OPC_ISSUE_RO, 28'hFFF0007),
			ins(rsq_pkg::OPC_END, 28'h0)});
		c = pulses;
		go(n);
		repeat (30) @(posedge clk);
		chk(pulses, c + 1);
		chk({16'h0, last_slot}, 32'h7);
		chk({16'h0, last_wunit}, 32'hFFF);
		chk({30'h0, trig_out}, 32'h2);
		st(32'h21);
	endtask
	task automatic t_sources;
		logic [4:0] src[6] = '{5'h01, 5'h07, 5'h14, 5'h08, 5'h0C, 5'h10};
		int f[6] = '{1, 2, 3, 0, 0, 0};
		int n;
		load('{ins(rsq_pkg::OPC_SET_TRIG, 28'h3),
			ins(rsq_pkg::OPC_ISSUE_RO, 28'h10001),
			ins(rsq_pkg::OPC_WAIT_DIG, 28'h0),
			ins(rsq_pkg::OPC_ISSUE_RO, 28'h10001),
			ins(rsq_pkg::OPC_END, 28'h0)});
		for (int i = 0; i < 6; i++) begin
			repeat (8) @(posedge clk);
			wr(rsq_pkg::ADDR_TRIGSEL, {27'h0, src[i]});
			go(n);
			fire(f[i]);
		end
	endtask
	task automatic t_waits;
		load('{ins(rsq_pkg::OPC_WAIT_SYNC, 28'h0),
			ins(rsq_pkg::OPC_ISSUE_RO, 28'h1),
			ins(rsq_pkg::OPC_WAIT_PIO, 28'h0),
			ins(rsq_pkg::OPC_ISSUE_RO, 28'h1),
			ins(rsq_pkg::OPC_WAIT_DIG, 28'h1),
			ins(rsq_pkg::OPC_ISSUE_RO, 28'h1),
			ins(rsq_pkg::OPC_END, 28'h0)});
		wr(rsq_pkg::ADDR_TRIGSEL, 32'h0100);
		wr(rsq_pkg::ADDR_PIOSEL, 32'h0105);
		wr(rsq_pkg::ADDR_CTRL, 32'h5);
		fire(4);
		fire(5);
		fire(1);
	endtask
	task automatic t_delay;
		int n;
		load('{ins(rsq_pkg::OPC_IDLE_DELAY, 28'd40),
			ins(rsq_pkg::OPC_IDLE_DELAY, 28'd30),
			ins(rsq_pkg::OPC_ISSUE_RO, 28'h1),
			ins(rsq_pkg::OPC_IDLE_DELAY, 28'd3),
			ins(rsq_pkg::OPC_ISSUE_RO, 28'h1),
			ins(rsq_pkg::OPC_END, 28'h0)});
		go(n);
		chk({31'h0, n >= 38 && n <= 60}, 32'h1);
		see(pulses, n);
		chk({31'h0, n >= 25 && n <= 45}, 32'h1);
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		{rst_n, sync, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
		{awaddr, araddr, wdata} = 48'h0;
		{pin_a, pin_b} = 8'h00;
		pio = 32'hFFFFFFFF;
		err_count = 0;
		tests_run = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_ready;
		t_fail;
		t_rerun;
		t_fields;
		t_sources;
		t_waits;
		t_delay;
		end_sim;
	end
endmodule
`default_nettype wire

// ==== include/rsq_pkg.sv ====
`default_nettype none
package rsq_pkg;
	// Instruction word layout: opcode in the top nibble, argument below.
	localparam int INSTR_W     = 32;
	localparam int OPC_LSB     = 28;
	localparam int ARG_W       = 28;
	localparam int PROG_AW     = 10;
	localparam int SLOT_W      = 16;
	localparam int WUNIT_W     = 16;
	localparam int SRC_W       = 5;
	localparam int CH_COUNT    = 4;
	localparam int SEQ_COUNT   = 4;

	// Opcodes.
	localparam logic [3:0] OPC_END         = 4'h0;
	localparam logic [3:0] OPC_IDLE_DELAY  = 4'h1;
	localparam logic [3:0] OPC_WAIT_SYNC   = 4'h2;
	localparam logic [3:0] OPC_WAIT_DIG    = 4'h3;
	localparam logic [3:0] OPC_WAIT_PIO    = 4'h4;
	localparam logic [3:0] OPC_SET_TRIG    = 4'h5;
	localparam logic [3:0] OPC_ISSUE_RO    = 4'h6;
	localparam logic [3:0] OPC_JUMP        = 4'h7;

	// Fields of the readout-issue argument.
	localparam int RO_SLOT_LSB  = 0;
	localparam int RO_WUNIT_LSB = 16;
	localparam int RO_WUNIT_W   = 12;

	// AXI4-Lite register byte addresses.
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_TRIGSEL  = 8'h08;
	localparam logic [7:0] ADDR_PIOSEL   = 8'h0C;
	localparam logic [7:0] ADDR_SWTRIG   = 8'h10;
	localparam logic [7:0] ADDR_PADDR    = 8'h14;
	localparam logic [7:0] ADDR_PDATA    = 8'h18;
	localparam logic [7:0] ADDR_PLEN     = 8'h1C;
	localparam logic [7:0] ADDR_DIAG     = 8'h20;

	// Control bits.
	localparam int CTRL_ENABLE  = 0;
	localparam int CTRL_RERUN   = 1;
	localparam int CTRL_LOADED  = 2;
	localparam int CTRL_FAILED  = 3;
	// Status bits.
	localparam int ST_READY     = 0;
	localparam int ST_RUNNING   = 1;
	localparam int ST_FAILED    = 2;
	localparam int ST_TRIG_LSB  = 4;
	// Trigger source select fields.
	localparam int TS1_LSB      = 0;
	localparam int TS2_LSB      = 8;
	// Parallel bus trigger select: bit index and polarity.
	localparam int PIO_IDX_W    = 5;
	localparam int PIO_POL_BIT  = 8;

	// Digital trigger source encoding (5 bits).
	localparam logic [4:0] SRC_PIN_A   = 5'h00;
	localparam logic [4:0] SRC_PIN_B   = 5'h04;
	localparam logic [4:0] SRC_SEQ_T1  = 5'h08;
	localparam logic [4:0] SRC_SEQ_T2  = 5'h0C;
	localparam logic [4:0] SRC_RO_DONE = 5'h10;
	localparam logic [4:0] SRC_SW      = 5'h14;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_FETCH = 3'b001,
		ST_EXEC  = 3'b010,
		ST_WAIT  = 3'b011,
		ST_STALL = 3'b100
	} rsq_state_type;
endpackage
`default_nettype wire

// ==== rtl/rsq_prog_mem.sv ====
`default_nettype none
module rsq_prog_mem #(
	parameter int AW = 10,
	parameter int DW = 32
) (
	input  wire logic          CLK,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge CLK) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

// ==== rtl/rsq_sync3.sv ====
`default_nettype none
// Three-stage input conditioner: a change is accepted once stages two and
// three agree, so the first stage is never read by logic.
module rsq_sync3 #(
	parameter int W = 1
) (
	input  wire logic         CLK,
	input  wire logic         RST_N,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			dout   <= '0;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			dout   <= (s2_reg & s3_reg) | (dout & (s2_reg | s3_reg));
		end
	end
endmodule
`default_nettype wire

// ==== rtl/rsq_top.sv ====
`default_nettype none
// Notes on behaviour
// - With rerun set, the program starts again from address zero on its end.
// - Two digital trigger inputs, each with its own source select.
// - Sources are pins A and B, sequencer outputs, readout done, software.
// - A parallel-bus trigger uses a selected bit and a selected polarity.
// - No path exists from the sequencer into any waveform memory.
// - Execution starts only on enable, given after a loaded program.
// - Ready shows only after a good compile and a fully loaded program.
// - A failed compile leaves diagnostic codes readable in status.
// - Readout issue pulses slot starts, weight starts and a monitor trigger.
// - The first idle delay sets trigger-to-pulse, later ones the spacing.
// - An idle delay does not stall; a second one waits for the first.
// - Trigger waits may use the sync link or a digital trigger.
// - The trigger-output instruction uses only its two low argument bits.
module rsq_top #(
	parameter int CH  = rsq_pkg::CH_COUNT,
	parameter int SEQ = rsq_pkg::SEQ_COUNT,
	parameter int AW  = rsq_pkg::PROG_AW
) (
	input  wire logic                        CLK,
	input  wire logic                        RST_N,
	input  wire logic [7:0]                  S_AXI_AWADDR,
	input  wire logic                        S_AXI_AWVALID,
	output logic                             S_AXI_AWREADY,
	input  wire logic [31:0]                 S_AXI_WDATA,
	input  wire logic [3:0]                  S_AXI_WSTRB,
	input  wire logic                        S_AXI_WVALID,
	output logic                             S_AXI_WREADY,
	output logic [1:0]                       S_AXI_BRESP,
	output logic                             S_AXI_BVALID,
	input  wire logic                        S_AXI_BREADY,
	input  wire logic [7:0]                  S_AXI_ARADDR,
	input  wire logic                        S_AXI_ARVALID,
	output logic                             S_AXI_ARREADY,
	output logic [31:0]                      S_AXI_RDATA,
	output logic [1:0]                       S_AXI_RRESP,
	output logic                             S_AXI_RVALID,
	input  wire logic                        S_AXI_RREADY,
	input  wire logic [CH-1:0]               TRIG_PIN_A,
	input  wire logic [CH-1:0]               TRIG_PIN_B,
	input  wire logic [31:0]                 PARALLEL_IO_BUS,
	input  wire logic                        SYNC_LINK_TRIGGER,
	input  wire logic [2*SEQ-1:0]            SEQ_TRIG_IN,
	input  wire logic [CH-1:0]               READOUT_DONE,
	output logic [1:0]                       SEQ_TRIG_OUT,
	output logic [rsq_pkg::SLOT_W-1:0]       SLOT_START,
	output logic [rsq_pkg::WUNIT_W-1:0]      WEIGHT_START,
	output logic                             MONITOR_TRIG
);
	// ****************************************************************
	// Input conditioning
	// ****************************************************************
	localparam int NIN = 2*CH + 33;
	logic [NIN-1:0] pins_s;

	rsq_sync3 #(.W(NIN)) u_sync (
		.CLK  (CLK),
		.RST_N(RST_N),
		.din  ({SYNC_LINK_TRIGGER, PARALLEL_IO_BUS, TRIG_PIN_B, TRIG_PIN_A}),
		.dout (pins_s)
	);

	typedef struct packed {
		rsq_pkg::rsq_state_type       st;
		logic [AW-1:0]                pc;
		logic [rsq_pkg::INSTR_W-1:0]  ir;
		logic                         en;
		logic                         rerun;
		logic                         loaded;
		logic                         failed;
		logic [15:0]                  diag;
		logic [15:0]                  trig_sel;
		logic [8:0]                   pio_sel;
		logic [1:0]                   sw_trig;
		logic [AW-1:0]                waddr;
		logic [AW:0]                  plen;
		logic [AW:0]                  wcount;
		logic [rsq_pkg::ARG_W-1:0]    dly;
		logic                         aw_got;
		logic                         w_got;
		logic [7:0]                   awaddr;
		logic [31:0]                  wdata;
		logic                         bvalid;
		logic [1:0]                   bresp;
		logic                         rvalid;
		logic [31:0]                  rdata;
		logic [1:0]                   rresp;
		logic [1:0]                   trig_out;
		logic [rsq_pkg::SLOT_W-1:0]   slot;
		logic [rsq_pkg::WUNIT_W-1:0]  wunit;
		logic                         mon;
	} rsq_regs_type;

	rsq_regs_type r_reg;
	rsq_regs_type r_next;
	logic                         mem_we;
	logic [rsq_pkg::INSTR_W-1:0]  mem_rdata;

	// Instruction memory written only from the bus; the sequencer itself
	// drives no data path toward waveform storage.
	// no waveform write
	rsq_prog_mem #(.AW(AW), .DW(rsq_pkg::INSTR_W)) u_mem (
		.CLK  (CLK),
		.we   (mem_we),
		.waddr(r_reg.waddr),
		.wdata(r_reg.wdata),
		.raddr(r_reg.pc),
		.rdata(mem_rdata)
	);

	// Pick one digital trigger from its five-bit source code.
	function automatic logic pick_src(input logic [4:0] sel,
			input logic [NIN-1:0] p, input logic [2*SEQ-1:0] sq,
			input logic [CH-1:0] rd, input logic sw);
		logic [1:0] i;
		i = sel[1:0];
		pick_src = 1'b0;
		if (sel[4:2] == rsq_pkg::SRC_PIN_A[4:2]) begin
			pick_src = p[i];
		end else if (sel[4:2] == rsq_pkg::SRC_PIN_B[4:2]) begin
			pick_src = p[CH + i];
		end else if (sel[4:2] == rsq_pkg::SRC_SEQ_T1[4:2]) begin
			pick_src = sq[2*i];
		end else if (sel[4:2] == rsq_pkg::SRC_SEQ_T2[4:2]) begin
			pick_src = sq[2*i + 1];
		end else if (sel[4:2] == rsq_pkg::SRC_RO_DONE[4:2]) begin
			pick_src = rd[i];
		end else if (sel[4:2] == rsq_pkg::SRC_SW[4:2]) begin
			pick_src = sw;
		end
	endfunction

	// ****************************************************************
	// Trigger selection
	// ****************************************************************
	logic [1:0] dig_trig;
	logic       pio_trig;
	logic       sync_trig;
	logic [3:0] opc;
	logic [rsq_pkg::ARG_W-1:0] arg;

	always_comb begin
		for (int k = 0; k < 2; k++) begin
			dig_trig[k] = pick_src(r_reg.trig_sel[8*k +: rsq_pkg::SRC_W],
				pins_s, SEQ_TRIG_IN, READOUT_DONE, r_reg.sw_trig[k]);
		end
		pio_trig = pins_s[2*CH + r_reg.pio_sel[rsq_pkg::PIO_IDX_W-1:0]]
			^ r_reg.pio_sel[rsq_pkg::PIO_POL_BIT];
		sync_trig = pins_s[NIN-1];
		opc = r_reg.ir[rsq_pkg::INSTR_W-1:rsq_pkg::OPC_LSB];
		arg = r_reg.ir[rsq_pkg::ARG_W-1:0];
	end

	// ****************************************************************
	// Sequencer and register bus
	// ****************************************************************
	always_comb begin
		logic wr_go;
		logic rd_go;
		logic ready;
		wr_go = 1'b0;
		rd_go = 1'b0;
		ready = 1'b0;
		r_next = r_reg;
		r_next.slot = '0;
		r_next.wunit = '0;
		r_next.mon = 1'b0;
		mem_we = 1'b0;
		ready = r_reg.loaded && !r_reg.failed && (r_reg.wcount == r_reg.plen)
			&& (r_reg.plen != '0);
		if (r_reg.dly != '0) begin
			r_next.dly = r_reg.dly - 1'b1;
		end

		case (r_reg.st)
			rsq_pkg::ST_IDLE: begin
				r_next.pc = '0;
				if (r_reg.en && ready) begin
					r_next.st = rsq_pkg::ST_FETCH;
				end
			end
			rsq_pkg::ST_FETCH: begin
				r_next.pc = r_reg.pc + 1'b1;
				r_next.st = rsq_pkg::ST_EXEC;
			end
			rsq_pkg::ST_EXEC: begin
				r_next.ir = mem_rdata;
				r_next.st = rsq_pkg::ST_WAIT;
			end
			default: begin
				r_next.st = rsq_pkg::ST_FETCH;
				case (opc)
					rsq_pkg::OPC_END: begin
						r_next.pc = '0;
						if (!(r_reg.rerun && r_reg.en)) begin
							r_next.st = rsq_pkg::ST_IDLE;
							r_next.en = 1'b0;
						end
					end
					rsq_pkg::OPC_IDLE_DELAY: begin
						if (r_reg.dly != '0) begin
							r_next.st = rsq_pkg::ST_WAIT;
						end else begin
							r_next.dly = arg;
						end
					end
					rsq_pkg::OPC_WAIT_SYNC: begin
						if (!sync_trig) begin
							r_next.st = rsq_pkg::ST_WAIT;
						end
					end
					rsq_pkg::OPC_WAIT_DIG: begin
						if (!dig_trig[arg[0]]) begin
							r_next.st = rsq_pkg::ST_WAIT;
						end
					end
					rsq_pkg::OPC_WAIT_PIO: begin
						if (!pio_trig) begin
							r_next.st = rsq_pkg::ST_WAIT;
						end
					end
					rsq_pkg::OPC_SET_TRIG: begin
						r_next.trig_out = arg[1:0];
					end
					rsq_pkg::OPC_ISSUE_RO: begin
						r_next.slot = arg[rsq_pkg::RO_SLOT_LSB +: rsq_pkg::SLOT_W];
						r_next.wunit = {4'h0,
							arg[rsq_pkg::RO_WUNIT_LSB +: rsq_pkg::RO_WUNIT_W]};
						r_next.mon = 1'b1;
					end
					rsq_pkg::OPC_JUMP: begin
						r_next.pc = arg[AW-1:0];
					end
					default: begin
					end
				endcase
				// Disable stops a running program at the next instruction.
				if (!r_reg.en) begin
					r_next.st = rsq_pkg::ST_IDLE;
				end
			end
		endcase

		// Write channel: address and data taken in either order.
		if (S_AXI_AWVALID && !r_reg.aw_got && !r_reg.bvalid) begin
			r_next.aw_got = 1'b1;
			r_next.awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !r_reg.w_got && !r_reg.bvalid) begin
			r_next.w_got = 1'b1;
			r_next.wdata = S_AXI_WDATA;
		end
		if (r_reg.aw_got && r_reg.w_got) begin
			wr_go = 1'b1;
			r_next.aw_got = 1'b0;
			r_next.w_got = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = rsq_pkg::RESP_OKAY;
		end
		if (r_reg.bvalid && S_AXI_BREADY) begin
			r_next.bvalid = 1'b0;
		end
		r_next.sw_trig = '0;
		if (wr_go) begin
			if (r_reg.awaddr == rsq_pkg::ADDR_CTRL) begin
				r_next.en = r_reg.wdata[rsq_pkg::CTRL_ENABLE];
				r_next.rerun = r_reg.wdata[rsq_pkg::CTRL_RERUN];
				r_next.loaded = r_reg.wdata[rsq_pkg::CTRL_LOADED];
				r_next.failed = r_reg.wdata[rsq_pkg::CTRL_FAILED];
			end else if (r_reg.awaddr == rsq_pkg::ADDR_TRIGSEL) begin
				r_next.trig_sel = r_reg.wdata[15:0];
			end else if (r_reg.awaddr == rsq_pkg::ADDR_PIOSEL) begin
				r_next.pio_sel = r_reg.wdata[8:0];
			end else if (r_reg.awaddr == rsq_pkg::ADDR_SWTRIG) begin
				r_next.sw_trig = r_reg.wdata[1:0];
			end else if (r_reg.awaddr == rsq_pkg::ADDR_PADDR) begin
				r_next.waddr = r_reg.wdata[AW-1:0];
				r_next.wcount = '0;
				r_next.loaded = 1'b0;
			end else if (r_reg.awaddr == rsq_pkg::ADDR_PDATA) begin
				// Loading while running would corrupt the live program.
				mem_we = (r_reg.st == rsq_pkg::ST_IDLE);
				r_next.waddr = r_reg.waddr + 1'b1;
				r_next.wcount = r_reg.wcount + 1'b1;
			end else if (r_reg.awaddr == rsq_pkg::ADDR_PLEN) begin
				r_next.plen = r_reg.wdata[AW:0];
			end else if (r_reg.awaddr == rsq_pkg::ADDR_DIAG) begin
				r_next.diag = r_reg.wdata[15:0];
			end else begin
				r_next.bresp = rsq_pkg::RESP_SLVERR;
			end
		end

		if (S_AXI_ARVALID && !r_reg.rvalid) begin
			rd_go = 1'b1;
		end
		if (r_reg.rvalid && S_AXI_RREADY) begin
			r_next.rvalid = 1'b0;
		end
		if (rd_go) begin
			r_next.rvalid = 1'b1;
			r_next.rresp = rsq_pkg::RESP_OKAY;
			r_next.rdata = '0;
			if (S_AXI_ARADDR == rsq_pkg::ADDR_CTRL) begin
				r_next.rdata[3:0] = {r_reg.failed, r_reg.loaded,
					r_reg.rerun, r_reg.en};
			end else if (S_AXI_ARADDR == rsq_pkg::ADDR_STATUS) begin
				r_next.rdata[rsq_pkg::ST_READY] = ready;
				r_next.rdata[rsq_pkg::ST_RUNNING] =
					(r_reg.st != rsq_pkg::ST_IDLE);
				r_next.rdata[rsq_pkg::ST_FAILED] = r_reg.failed;
				r_next.rdata[rsq_pkg::ST_TRIG_LSB +: 2] = r_reg.trig_out;
				r_next.rdata[31:16] = r_reg.failed ? r_reg.diag : 16'h0000;
			end else if (S_AXI_ARADDR == rsq_pkg::ADDR_TRIGSEL) begin
				r_next.rdata[15:0] = r_reg.trig_sel;
			end else if (S_AXI_ARADDR == rsq_pkg::ADDR_PIOSEL) begin
				r_next.rdata[8:0] = r_reg.pio_sel;
			end else if (S_AXI_ARADDR == rsq_pkg::ADDR_PADDR) begin
				r_next.rdata[AW-1:0] = r_reg.waddr;
			end else if (S_AXI_ARADDR == rsq_pkg::ADDR_PLEN) begin
				r_next.rdata[AW:0] = r_reg.plen;
			end else if (S_AXI_ARADDR == rsq_pkg::ADDR_DIAG) begin
				r_next.rdata[15:0] = r_reg.diag;
			end else if (S_AXI_ARADDR == rsq_pkg::ADDR_SWTRIG ||
					S_AXI_ARADDR == rsq_pkg::ADDR_PDATA) begin
				r_next.rdata = '0;
			end else begin
				r_next.rresp = rsq_pkg::RESP_SLVERR;
			end
		end
		S_AXI_ARREADY = rd_go;
		S_AXI_AWREADY = S_AXI_AWVALID && !r_reg.aw_got && !r_reg.bvalid;
		S_AXI_WREADY = S_AXI_WVALID && !r_reg.w_got && !r_reg.bvalid;
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign S_AXI_BVALID = r_reg.bvalid;
	assign S_AXI_BRESP  = r_reg.bresp;
	assign S_AXI_RVALID = r_reg.rvalid;
	assign S_AXI_RDATA  = r_reg.rdata;
	assign S_AXI_RRESP  = r_reg.rresp;
	assign SEQ_TRIG_OUT = r_reg.trig_out;
	assign SLOT_START   = r_reg.slot;
	assign WEIGHT_START = r_reg.wunit;
	assign MONITOR_TRIG = r_reg.mon;
endmodule
`default_nettype wire
